//--- rtl/cci_top.v
// Calibration command interpreter: decodes command/data byte pairs,
// holds coefficients, and streams raw samples while in raw mode with bridge gain at unity.
// Assumes rxByte/rxStrobe come from a deserialiser on clk, and raw
// readings are presented with a one-cycle sampleStrobe on clk.
`timescale 1ns/1ps
`include "cci_defines.vh"
module cci_top
(
  input  wire        clk,
  input  wire        arst_n,
  input  wire [7:0]  rxByte,
  input  wire        rxStrobe,
  input  wire [13:0] rawBridge,
  input  wire [10:0] rawTemp,
  input  wire        sampleStrobe,
  output reg  [7:0]  txByte,
  output reg         txValid,
  input  wire        txReady,
  output reg         commandMode,
  output reg         rawMode,
  output reg         rawActive,
  output reg  [14:0] bridgeGain,
  output reg  [13:0] bridgeOffset,
  output reg  [7:0]  tempGain,
  output reg  [7:0]  tempOffset,
  output reg  [7:0]  offsetTc,
  output reg  [7:0]  gainTc,
  output reg  [6:0]  clipHigh,
  output reg  [6:0]  clipLow,
  output reg  [23:0] serialNumber,
  output reg         sampleDropped
);
  localparam ST_IDLE = 2'd0;
  localparam ST_BHI  = 2'd1;
  localparam ST_BLO  = 2'd2;
  localparam ST_TMP  = 2'd3;

  reg        haveCmd_r;
  reg  [7:0] cmdByte_r;
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [13:0] bridgeHold_r;
  reg  [7:0] tempHold_r;
  reg  [7:0] bufIn;
  reg        bufInValid;
  wire       bufInReady;
  wire [7:0] bufOutData;
  wire       bufOutValid;
  wire       pairDone;
  wire       rawOk;
  wire       outLoad;
  wire       wrEn;
  wire       wrGainHi;
  wire       wrGainLo;
  wire       wrOffHi;
  wire       wrOffLo;
  wire       wrTempGain;
  wire       wrTempOff;
  wire       wrOffTc;
  wire       wrGainTc;
  wire       wrClipHi;
  wire       wrClipLo;
  wire       wrSer0;
  wire       wrSer1;
  wire       wrSer2;

  // Match a command byte; used across the whole decode
  function isCmd;
    input [7:0] got;
    input [7:0] want;
    begin
      isCmd = (got == want);
    end
  endfunction

  assign pairDone = haveCmd_r & rxStrobe;
  assign rawOk    = rawMode & (bridgeGain == `CCI_GAINB_UNITY);

  // Byte pairing: first byte is command, second is its data
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      haveCmd_r <= 1'b0;
      cmdByte_r <= `CCI_BYTE_RST;
    end
    else if (rxStrobe)
    begin
      haveCmd_r <= ~haveCmd_r;
      if (!haveCmd_r)
        cmdByte_r <= rxByte;
    end
  end

  // Mode control; start pair is honoured in any mode
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      commandMode <= 1'b0;
      rawMode     <= 1'b0;
    end
    else if (pairDone)
    begin
      if (isCmd(cmdByte_r, `CCI_CMD_START) &&
          rxByte == `CCI_DAT_START)
        commandMode <= 1'b1;
      else if (commandMode && isCmd(cmdByte_r, `CCI_CMD_MODE))
      begin
        if (rxByte == `CCI_DAT_NORMAL)
        begin
          commandMode <= 1'b0;
          rawMode     <= 1'b0;
        end
        else if ((rxByte & `CCI_DAT_RAW_MASK) != 8'h00)
          rawMode <= 1'b1;
      end
    end
  end

  // One write strobe per command; only a full pair in command mode counts
  assign wrEn       = pairDone & commandMode;
  assign wrGainHi   = wrEn & isCmd(cmdByte_r, `CCI_CMD_GAINB_HI);
  assign wrGainLo   = wrEn & isCmd(cmdByte_r, `CCI_CMD_GAINB_LO);
  assign wrOffHi    = wrEn & isCmd(cmdByte_r, `CCI_CMD_OFFB_HI);
  assign wrOffLo    = wrEn & isCmd(cmdByte_r, `CCI_CMD_OFFB_LO);
  assign wrTempGain = wrEn & isCmd(cmdByte_r, `CCI_CMD_GAINT);
  assign wrTempOff  = wrEn & isCmd(cmdByte_r, `CCI_CMD_OFFT);
  assign wrOffTc    = wrEn & isCmd(cmdByte_r, `CCI_CMD_TCO);
  assign wrGainTc   = wrEn & isCmd(cmdByte_r, `CCI_CMD_TCG);
  assign wrClipHi   = wrEn & isCmd(cmdByte_r, `CCI_CMD_CLIP_HI);
  assign wrClipLo   = wrEn & isCmd(cmdByte_r, `CCI_CMD_CLIP_LO);
  assign wrSer0     = wrEn & isCmd(cmdByte_r, `CCI_CMD_SER0);
  assign wrSer1     = wrEn & isCmd(cmdByte_r, `CCI_CMD_SER1);
  assign wrSer2     = wrEn & isCmd(cmdByte_r, `CCI_CMD_SER2);

  // Bridge gain halves; unity after reset so raw mode works untrimmed
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      bridgeGain <= `CCI_GAINB_RST;
    else if (wrGainHi)
      bridgeGain[14:8] <= rxByte[6:0];
    else if (wrGainLo)
      bridgeGain[7:0] <= rxByte;
  end

  // Bridge offset halves; extra data bits are dropped, not checked
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      bridgeOffset <= `CCI_OFFB_RST;
    else if (wrOffHi)
      bridgeOffset[13:8] <= rxByte[5:0];
    else if (wrOffLo)
      bridgeOffset[7:0] <= rxByte;
  end

  // Temperature terms, a full byte each
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tempGain   <= `CCI_GAINT_RST;
      tempOffset <= `CCI_BYTE_RST;
      offsetTc   <= `CCI_BYTE_RST;
      gainTc     <= `CCI_BYTE_RST;
    end
    else if (wrTempGain)
      tempGain <= rxByte;
    else if (wrTempOff)
      tempOffset <= rxByte;
    else if (wrOffTc)
      offsetTc <= rxByte;
    else if (wrGainTc)
      gainTc <= rxByte;
  end

  // Clipping limits; the top data bit has no home and is ignored
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clipHigh <= `CCI_CLIP_RST;
      clipLow  <= `CCI_CLIP_RST;
    end
    else if (wrClipHi)
      clipHigh <= rxByte[6:0];
    else if (wrClipLo)
      clipLow <= rxByte[6:0];
  end

  // Serial number bytes; byte 0 is the least significant
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      serialNumber <= {3{`CCI_BYTE_RST}};
    else if (wrSer0)
      serialNumber[7:0] <= rxByte;
    else if (wrSer1)
      serialNumber[15:8] <= rxByte;
    else if (wrSer2)
      serialNumber[23:16] <= rxByte;
  end

  // Raw sample framing: three bytes per sample, in fixed order
  always @*
  begin
    state_nxt  = state_r;
    bufIn      = 8'h00;
    bufInValid = 1'b0;
    case (state_r)
      ST_IDLE:
        if (sampleStrobe && rawOk)
          state_nxt = ST_BHI;
      ST_BHI:
      begin
        bufIn      = {2'b00, bridgeHold_r[13:8]};
        bufInValid = 1'b1;
        if (bufInReady)
          state_nxt = ST_BLO;
      end
      ST_BLO:
      begin
        bufIn      = bridgeHold_r[7:0];
        bufInValid = 1'b1;
        if (bufInReady)
          state_nxt = ST_TMP;
      end
      ST_TMP:
      begin
        bufIn      = tempHold_r;
        bufInValid = 1'b1;
        if (bufInReady)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Latch a sample when idle; a sample mid-frame is dropped and flagged
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r       <= ST_IDLE;
      bridgeHold_r  <= 14'h0000;
      tempHold_r    <= 8'h00;
      sampleDropped <= 1'b0;
      rawActive     <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      rawActive     <= rawOk;
      sampleDropped <= sampleStrobe & rawOk & (state_r != ST_IDLE);
      if (state_r == ST_IDLE && sampleStrobe && rawOk)
      begin
        bridgeHold_r <= rawBridge;
        tempHold_r   <= rawTemp[7:0];
      end
    end
  end

  cci_skid u_skid
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .inData   (bufIn),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .outData  (bufOutData),
    .outValid (bufOutValid),
    .outReady (outLoad)
  );

  // Skid lets go only of a byte the output register really takes;
  // popping on txReady alone would send a byte twice after a stall
  assign outLoad = ~txValid | txReady;

  // Registered output stage; refilled whenever it is empty or taken
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txByte  <= `CCI_BYTE_RST;
      txValid <= 1'b0;
    end
    else if (outLoad)
    begin
      txByte  <= bufOutData;
      txValid <= bufOutValid;
    end
  end
endmodule

//--- rtl/cci_defines.vh
// Constants for the calibration command interpreter.
// Assumes bytes arrive already deserialised from the one-wire link.
`ifndef CCI_DEFINES_VH
`define CCI_DEFINES_VH
`define CCI_CMD_GAINB_HI  8'h80
`define CCI_CMD_GAINB_LO  8'h90
`define CCI_CMD_OFFB_HI   8'ha0
`define CCI_CMD_OFFB_LO   8'hb0
`define CCI_CMD_GAINT     8'hc0
`define CCI_CMD_OFFT      8'hd0
`define CCI_CMD_TCO       8'he0
`define CCI_CMD_TCG       8'hf0
`define CCI_CMD_CLIP_HI   8'h08
`define CCI_CMD_CLIP_LO   8'h18
`define CCI_CMD_SER0      8'h28
`define CCI_CMD_SER1      8'h38
`define CCI_CMD_SER2      8'h48
`define CCI_CMD_MODE      8'h40
`define CCI_CMD_START     8'h50
`define CCI_DAT_START     8'h90
`define CCI_DAT_NORMAL    8'h00
`define CCI_DAT_RAW_MASK  8'h10
`define CCI_GAINB_UNITY   15'h0800
`define CCI_GAINB_RST     15'h0800
`define CCI_GAINT_RST     8'h80
`define CCI_BYTE_RST      8'h00
`define CCI_OFFB_RST      14'h0000
`define CCI_CLIP_RST      7'h00
`endif

//--- rtl/cci_skid.v
// Two-entry buffer in the outgoing byte path.
// Assumes both sides on the same clock; ready may drop at any time.
`timescale 1ns/1ps
module cci_skid
(
  input  wire       clk,
  input  wire       arst_n,
  input  wire [7:0] inData,
  input  wire       inValid,
  output wire       inReady,
  output wire [7:0] outData,
  output wire       outValid,
  input  wire       outReady
);
  reg [7:0] mem_r [0:1];
  reg       wrPtr_r;
  reg       rdPtr_r;
  reg [1:0] count_r;
  wire      push;
  wire      pop;

  // Honest full and empty flags from the count
  assign inReady  = (count_r != 2'd2);
  assign outValid = (count_r != 2'd0);
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Storage is not reset; valid gating hides stale words
  always @(posedge clk)
  begin
    if (push)
      mem_r[wrPtr_r] <= inData;
  end

  // Pointers and occupancy
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'd0;
    end
    else
    begin
      if (push)
        wrPtr_r <= ~wrPtr_r;
      if (pop)
        rdPtr_r <= ~rdPtr_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- tb/cci_top_assertions.sv
// Checker for cci_top, seeing its ports only.
// Assumes byte pairing restarts only at reset, like the design.
`timescale 1ns/1ps
module cci_top_assertions
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  rxByte,
  input wire logic        rxStrobe,
  input wire logic [7:0]  txByte,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic        commandMode,
  input wire logic        rawMode,
  input wire logic        rawActive,
  input wire logic [14:0] bridgeGain,
  input wire logic [13:0] bridgeOffset
);
  logic       dataPhase_r;
  logic [7:0] cmd_r;
  wire        dStb = rxStrobe && dataPhase_r;
  wire        inCm = dStb && commandMode;
  // Pair tracking, so each data byte is judged with its command
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      dataPhase_r <= 1'b0;
      cmd_r <= 8'h00;
    end
    else if (rxStrobe)
    begin
      dataPhase_r <= !dataPhase_r;
      cmd_r <= dataPhase_r ? cmd_r : rxByte;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_enter_cmd: assert property (dStb && cmd_r == 8'h50 &&
    rxByte == 8'h90 |=> commandMode) else $error("no command mode");
  chk_exit_normal: assert property (inCm && cmd_r == 8'h40 &&
    rxByte == 8'h00 |=> !commandMode && !rawMode) else $error("no exit");
  chk_raw_entry: assert property (inCm && cmd_r == 8'h40 &&
    rxByte[4] |=> rawMode) else $error("no raw mode");
  chk_gain_high: assert property (inCm && cmd_r == 8'h80
    |=> bridgeGain[14:8] == $past(rxByte[6:0])) else $error("gain hi");
  chk_gain_low: assert property (inCm && cmd_r == 8'h90
    |=> bridgeGain[7:0] == $past(rxByte)) else $error("gain lo");
  chk_offset_high: assert property (inCm && cmd_r == 8'ha0
    |=> bridgeOffset[13:8] == $past(rxByte[5:0])) else $error("off hi");
  chk_cmd_waits: assert property (rxStrobe && !dataPhase_r
    |=> $stable(bridgeGain) && $stable(commandMode)) else $error("early");
  chk_raw_active: assert property (rawActive ==
    $past(rawMode && bridgeGain == 15'h0800)) else $error("raw active");
  chk_stall_hold: assert property (txValid && !txReady
    |=> txValid && $stable(txByte)) else $error("stall lost byte");
  cover property (inCm && cmd_r == 8'h40 && rxByte[4]);
  cover property (txValid && !txReady);
  cover property (rawActive && txValid && txReady);
endmodule
bind cci_top cci_top_assertions chk
(
  .clk(clk), .arst_n(arst_n), .rxByte(rxByte), .rxStrobe(rxStrobe),
  .txByte(txByte), .txValid(txValid), .txReady(txReady),
  .commandMode(commandMode), .rawMode(rawMode), .rawActive(rawActive),
  .bridgeGain(bridgeGain), .bridgeOffset(bridgeOffset)
);

//--- tb/cci_master.sv
// Calibration master model: sends byte pairs, collects raw bytes.
// Assumes one byte per clock on the link; it stalls the raw stream.
`timescale 1ns/1ps
module cci_master
(
  input  wire logic       clk,
  input  wire logic [7:0] txByte,
  input  wire logic       txValid,
  output logic            txReady = 1'b0,
  output logic [7:0]      rxByte = 8'h00,
  output logic            rxStrobe = 1'b0
);
  logic [7:0] got[$];
  // Take bytes on valid and ready; ready wanders to force stalls
  always @(posedge clk)
  begin
    if (txValid && txReady)
      got.push_back(txByte);
    #2 txReady = ($urandom % 4) != 0;
  end
  // Command byte then data byte, strobe held across both
  task automatic sendPair(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk) #2;
    rxByte = c;
    rxStrobe = 1'b1;
    @(posedge clk) #2;
    rxByte = d;
    @(posedge clk) #2;
    rxStrobe = 1'b0;
    rxByte = ~d; // Idle line must not keep the data
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the calibration command interpreter.
// Assumes the master model and the bound checker beside it.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, arst_n = 1'b0, sampleStrobe = 1'b0;
  logic [13:0] rawBridge = 14'h0000, offB, b;
  logic [10:0] rawTemp = 11'h000, t;
  logic [7:0]  rxByte, txByte, tGain, tOff, tco, tcg, d;
  logic        rxStrobe, txValid, txReady, cmdMode, rawMode, rawAct;
  logic [14:0] gainB;
  logic [6:0]  clipH, clipL;
  logic [23:0] serial, raw;
  logic        drop, dbl;
  int          mismatches = 0, samples_checked = 0, cycles = 0;
  logic [7:0]  cmds[13] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc0, 8'hd0,
    8'he0, 8'hf0, 8'h08, 8'h18, 8'h28, 8'h38, 8'h48};
  always #12.5 clk = ~clk;
  cci_top dut (.clk(clk), .arst_n(arst_n), .rxByte(rxByte),
    .rxStrobe(rxStrobe), .rawBridge(rawBridge), .rawTemp(rawTemp),
    .sampleStrobe(sampleStrobe), .txByte(txByte), .txValid(txValid),
    .txReady(txReady), .commandMode(cmdMode), .rawMode(rawMode),
    .rawActive(rawAct), .bridgeGain(gainB), .bridgeOffset(offB),
    .tempGain(tGain), .tempOffset(tOff), .offsetTc(tco), .gainTc(tcg),
    .clipHigh(clipH), .clipLow(clipL), .serialNumber(serial),
    .sampleDropped(drop));
  cci_master m (.clk(clk), .txByte(txByte), .txValid(txValid),
    .txReady(txReady), .rxByte(rxByte), .rxStrobe(rxStrobe));
  task automatic check(input string n, input logic [23:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Ceiling far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end
  // Data as the master must send it, top bits cleared
  function automatic logic [7:0] clean(input logic [7:0] c, dat);
    case (c)
      8'h80: return dat & 8'h7f;
      8'h08, 8'h18: return dat & 8'h7f;
      8'ha0: return dat & 8'h3f;
      default: return dat;
    endcase
  endfunction
  // Field a command lands in
  function automatic logic [7:0] field(input logic [7:0] c);
    case (c)
      8'h80: return {1'b0, gainB[14:8]};
      8'h90: return gainB[7:0];
      8'ha0: return {2'b00, offB[13:8]};
      8'hb0: return offB[7:0];
      8'hc0: return tGain;
      8'hd0: return tOff;
      8'he0: return tco;
      8'hf0: return tcg;
      8'h08: return {1'b0, clipH};
      8'h18: return {1'b0, clipL};
      8'h28: return serial[7:0];
      8'h38: return serial[15:8];
      default: return serial[23:16];
    endcase
  endfunction
  // Main sequence: reset, refusal, writes, raw stream, exit
  initial
  begin
    void'($urandom(59));
    repeat (3) @(posedge clk);
    #2 arst_n = 1'b1;
    check("gainB", gainB, 24'h000800);
    check("tGain", tGain, 24'h000080);
    m.sendPair(8'h80, 8'h11);
    check("refused", gainB, 24'h000800);
    m.sendPair(8'h50, 8'h90);
    check("cmdMode", cmdMode, 24'h1);
    foreach (cmds[i])
    begin
      d = clean(cmds[i], $urandom);
      m.sendPair(cmds[i], d);
      check("field", field(cmds[i]), d);
    end
    m.sendPair(8'h80, 8'h08);
    m.sendPair(8'h90, 8'h00);
    m.sendPair(8'h40, 8'h10);
    @(posedge clk) #2;
    check("raw", {rawMode, rawAct}, 24'h3);
    // Two calibration points of sixteen readings each
    repeat (2 * 16)
    begin
      b = $urandom;
      t = $urandom;
      dbl = $urandom;
      m.got.delete();
      @(posedge clk) #2;
      {rawBridge, rawTemp, sampleStrobe} = {b, t, 1'b1};
      @(posedge clk) #2;
      // Optional second strobe lands mid-frame and must be dropped
      {rawBridge, sampleStrobe} = {~b, dbl};
      @(posedge clk) #2;
      check("dropped", drop, dbl);
      sampleStrobe = 1'b0;
      for (int k = 0; k < 60 && m.got.size() < 3; k++) @(posedge clk);
      raw = {m.got[0], m.got[1], m.got[2]};
      check("rawBytes", raw, {2'b00, b, t[7:0]});
    end
    // Offset TC is written again after the raw data is in
    d = $urandom;
    m.sendPair(8'he0, d);
    check("tco", tco, d);
    m.sendPair(8'h40, 8'h00);
    check("modes", {cmdMode, rawMode}, 24'h0);
    test_done();
  end
endmodule
